// File: iasq_defs.svh
`ifndef IASQ_DEFS_SVH
`define IASQ_DEFS_SVH

// Register byte offsets on the AHB-Lite slave.
`define IASQ_CTRL_OFS     8'h00
`define IASQ_CHEN_OFS     8'h04
`define IASQ_DIV_OFS      8'h08
`define IASQ_STAT_OFS     8'h0c
`define IASQ_FIFO_OFS     8'h10
`define IASQ_OFFS_BASE    8'h20
`define IASQ_GAIN_BASE    8'h40

// Control register bit positions.
`define IASQ_CTRL_START   0
`define IASQ_CTRL_STOP    1
`define IASQ_CTRL_BUF     2
// Status and FIFO register bit positions.
`define IASQ_ST_RUN       0
`define IASQ_ST_OVF       1
`define IASQ_ST_UP        2
`define IASQ_ST_DOWN      3
`define IASQ_ST_ID_LSB    4
`define IASQ_ST_SEL_LSB   8
`define IASQ_ST_CNT_LSB   16
`define IASQ_FIFO_VLD     31

// Reset values and limits.
`define IASQ_GAIN_RST     16'h8000
`define IASQ_DIV_MIN      32'd200
`define IASQ_CUR_FLOOR    16'h8000

// Time base: 40 MHz derived from the 200 MHz MCLK.
`define IASQ_CLK_MHZ      200
`define IASQ_TB_MHZ       40
`define IASQ_TB_DIV       (`IASQ_CLK_MHZ / `IASQ_TB_MHZ)

`endif

// File: iasq_pkg.sv
package iasq_pkg;
	typedef enum logic [1:0] {
		IASQ_IDLE  = 2'b00,
		IASQ_WAIT  = 2'b01,
		IASQ_CONV  = 2'b10,
		IASQ_STORE = 2'b11
	} iasq_state_type;
endpackage

// File: iasq_scan_seq.sv
// Function
// - Board identity is four switch bits, position 1 MSB, ON reads 0.
// - All identity switches at factory ON give identity zero.
// - Per-channel voltage/current selector is read and steers sample scaling.
// - Power indicator is green whenever the block is powered; the code holds it off while RESET is high.
// - Up indicator green while upstream is connected and running normally.
// - Upstream missing lights red and halts acquisition.
// - Downstream indicator blue while downstream connected, else off.
// - Exactly one channel routed to the shared converter at a time.
// - Offset/gain corrected sample goes to FIFO or straight to host.
// - Each result is a full-range 16-bit code; current-mode results are floored at 16'h8000.
// - Each of the channels has its own software enable bit.
// - Disabled channels are skipped and never converted.
// - Enabled channels scanned in ascending order, wrapping to lowest.
// - Sample ticks are 40 MHz divided by N, N at least 200.
// - Acquisition starts only on a software trigger.
// - Buffered FIFO holds 4096 samples shared by all channels.
// - Eight channels 0 to 7, each with enable and type select.
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "iasq_defs.svh"
module iasq_scan_seq #(
	parameter int NCH     = 8,
	parameter int DEPTH   = 4096,
	parameter int AW      = 12
) (
	input  wire logic        MCLK,	// 200 MHz clock
	input  wire logic        RESET,	// synchronous, active high
	input  wire logic        HSEL,	// AHB slave select
	input  wire logic [31:0] HADDR,	// AHB address
	input  wire logic [1:0]  HTRANS,	// AHB transfer type
	input  wire logic        HWRITE,	// AHB write
	input  wire logic [2:0]  HSIZE,	// AHB size, word only
	input  wire logic [31:0] HWDATA,	// AHB write data
	input  wire logic        HREADY,	// AHB bus ready
	output logic      [31:0] HRDATA,	// AHB read data
	output logic             HREADYOUT,	// AHB slave ready
	output logic             HRESP,	// always OKAY
	input  wire logic [3:0]  BOARD_ID_SW_ON,	// high = position ON
	input  wire logic [7:0]  TYPE_SEL_CURRENT,	// high = current
	input  wire logic        UPSTREAM_CONN,	// upstream link up
	input  wire logic        DOWNSTREAM_CONN,	// downstream link up
	output logic             LED_PWR_GREEN,	// power indicator
	output logic             LED_UP_GREEN,	// up/error green
	output logic             LED_UP_RED,	// up/error red
	output logic             LED_DOWN_BLUE,	// downstream indicator
	output logic [2:0]       MUX_SEL,	// analog_in channel select
	output logic             ADC_CONVST,	// conversion start pulse
	input  wire logic        ADC_DONE,	// conversion done pulse
	input  wire logic [15:0] ADC_DATA,	// raw code, offset binary
	output logic             SAMPLE_VALID,	// immediate sample pulse
	output logic [15:0]      SAMPLE_DATA,	// immediate sample data
	output logic [2:0]       SAMPLE_CHAN	// immediate sample channel
);
	function automatic logic [2:0] iasq_next(input logic [2:0] cur,
		input logic [7:0] en);
		logic [2:0] lo;
		logic [2:0] up;
		logic       fnd;
		lo = 3'h0;
		up = 3'h0;
		fnd = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (en[i]) begin
				lo = 3'(i);
			end
			if (en[i] && 3'(i) > cur) begin
				up = 3'(i);
				fnd = 1'b1;
			end
		end
		return fnd ? up : lo;
	endfunction

	// Gain is unsigned with 16'h8000 meaning unity; the result saturates.
	function automatic logic [15:0] iasq_correct(input logic [15:0] raw,
		input logic [15:0] off, input logic [15:0] gn, input logic cur);
		logic signed [17:0] s;
		logic signed [34:0] p;
		logic signed [19:0] q;
		logic        [15:0] r;
		s = $signed({2'b00, raw}) + $signed({{2{off[15]}}, off});
		p = 35'(s) * $signed({18'h0, gn});
		q = p[34:15];
		if (q < 0) begin
			r = 16'h0000;
		end else if (q > 20'sh0ffff) begin
			r = 16'hffff;
		end else begin
			r = q[15:0];
		end
		// The shunt only spans the upper half of the range.
		if (cur && r < `IASQ_CUR_FLOOR) begin
			r = `IASQ_CUR_FLOOR;
		end
		return r;
	endfunction

	iasq_pkg::iasq_state_type state_r, state_nxt;
	logic [7:0]  chen_r;
	logic [31:0] div_r;
	logic        buf_r, run_r, ovf_r;
	logic [2:0]  chan_r;
	logic [15:0] offs_r [NCH];
	logic [15:0] gain_r [NCH];
	logic [18:0] mem [DEPTH];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r;
	logic [2:0]  pre_r;
	logic [31:0] tbc_r;
	logic        tick_r;
	logic [3:0]  id_r;
	logic [7:0]  sel_r;
	logic [15:0] cor_r;
	logic        wr_pend_r, rd_pend_r;
	logic [7:0]  adr_r;

	wire        addr_ph  = HSEL && HTRANS[1] && HREADY;
	wire        wr_en    = wr_pend_r;
	wire        wr_ctrl  = wr_en && adr_r == `IASQ_CTRL_OFS;
	wire        start    = wr_ctrl && HWDATA[`IASQ_CTRL_START];
	wire        stop     = wr_ctrl && HWDATA[`IASQ_CTRL_STOP];
	wire        halt     = !UPSTREAM_CONN || stop || chen_r == 8'h00;
	wire        is_offs  = adr_r[7:5] == 3'b001;
	wire        is_gain  = adr_r[7:5] == 3'b010;
	wire [2:0]  reg_ch   = adr_r[4:2];
	wire        pop      = rd_pend_r && adr_r == `IASQ_FIFO_OFS
	                       && cnt_r != '0;
	wire        full     = cnt_r == (AW+1)'(DEPTH);
	wire        done_ok  = state_r == iasq_pkg::IASQ_CONV && ADC_DONE;
	wire        store    = state_r == iasq_pkg::IASQ_STORE;
	wire        push     = store && buf_r && !full;
	wire        ovf_set  = store && buf_r && full;
	wire        ovf_clr  = wr_en && adr_r == `IASQ_STAT_OFS
	                       && HWDATA[`IASQ_ST_OVF];
	wire [31:0] div_wr   = HWDATA < `IASQ_DIV_MIN ? `IASQ_DIV_MIN : HWDATA;
	wire        tb_en    = pre_r == 3'(`IASQ_TB_DIV - 1);
	wire [31:0] status   = 32'({cnt_r, sel_r, id_r, DOWNSTREAM_CONN,
	                        UPSTREAM_CONN, ovf_r, run_r});
	wire [18:0] head     = mem[rp_r];
	wire [31:0] rd_mux   =
		adr_r == `IASQ_CTRL_OFS ? {29'h0, buf_r, 2'b00} :
		adr_r == `IASQ_CHEN_OFS ? {24'h0, chen_r} :
		adr_r == `IASQ_DIV_OFS  ? div_r :
		adr_r == `IASQ_STAT_OFS ? status :
		adr_r == `IASQ_FIFO_OFS ? {cnt_r != '0, 12'h0, head} :
		is_offs ? {16'h0, offs_r[reg_ch]} :
		is_gain ? {16'h0, gain_r[reg_ch]} : 32'h0;

	// Reads take one wait state so that HRDATA comes from a flop.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			adr_r <= 8'h00;
			HREADYOUT <= 1'b1;
			HRDATA <= 32'h0;
			HRESP <= 1'b0;
		end else begin
			wr_pend_r <= addr_ph && HWRITE;
			rd_pend_r <= addr_ph && !HWRITE;
			HREADYOUT <= !(addr_ph && !HWRITE);
			if (addr_ph) begin
				adr_r <= HADDR[7:0];
			end
			if (rd_pend_r) begin
				HRDATA <= rd_mux;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			chen_r <= 8'h00;
			div_r <= `IASQ_DIV_MIN;
			buf_r <= 1'b1;
			for (int i = 0; i < NCH; i++) begin
				offs_r[i] <= 16'h0000;
				gain_r[i] <= `IASQ_GAIN_RST;
			end
		end else if (wr_en) begin
			if (adr_r == `IASQ_CHEN_OFS) begin
				chen_r <= HWDATA[7:0];
			end
			if (adr_r == `IASQ_DIV_OFS) begin
				div_r <= div_wr;
			end
			if (wr_ctrl) begin
				buf_r <= HWDATA[`IASQ_CTRL_BUF];
			end
			if (is_offs) begin
				offs_r[reg_ch] <= HWDATA[15:0];
			end
			if (is_gain) begin
				gain_r[reg_ch] <= HWDATA[15:0];
			end
		end
	end

	// Switch levels: ON reads 0, so all-ON is identity zero.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			id_r <= 4'h0;
			sel_r <= 8'h00;
		end else begin
			id_r <= ~BOARD_ID_SW_ON;
			sel_r <= TYPE_SEL_CURRENT;
		end
	end

	// Prescale to 40 MHz, then count N time-base ticks per sample.
	always_ff @(posedge MCLK) begin
		if (RESET || !run_r) begin
			pre_r <= 3'h0;
			tbc_r <= 32'h0;
			tick_r <= 1'b0;
		end else begin
			pre_r <= tb_en ? 3'h0 : pre_r + 3'h1;
			tick_r <= tb_en && tbc_r == div_r - 32'h1;
			if (tb_en) begin
				tbc_r <= tbc_r == div_r - 32'h1 ? 32'h0 : tbc_r + 32'h1;
			end
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			iasq_pkg::IASQ_IDLE: begin
				if (start && UPSTREAM_CONN && chen_r != 8'h00) begin
					state_nxt = iasq_pkg::IASQ_WAIT;
				end
			end
			iasq_pkg::IASQ_WAIT: begin
				if (tick_r) begin
					state_nxt = iasq_pkg::IASQ_CONV;
				end
			end
			iasq_pkg::IASQ_CONV: begin
				if (ADC_DONE) begin
					state_nxt = iasq_pkg::IASQ_STORE;
				end
			end
			iasq_pkg::IASQ_STORE: state_nxt = iasq_pkg::IASQ_WAIT;
			default: state_nxt = iasq_pkg::IASQ_IDLE;
		endcase
		if (halt) begin
			state_nxt = iasq_pkg::IASQ_IDLE;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			state_r <= iasq_pkg::IASQ_IDLE;
			run_r <= 1'b0;
			chan_r <= 3'h0;
			ADC_CONVST <= 1'b0;
			MUX_SEL <= 3'h0;
			cor_r <= 16'h0;
		end else begin
			state_r <= state_nxt;
			run_r <= state_nxt != iasq_pkg::IASQ_IDLE;
			ADC_CONVST <= state_r == iasq_pkg::IASQ_WAIT && tick_r && !halt;
			MUX_SEL <= chan_r;
			if (state_r == iasq_pkg::IASQ_IDLE) begin
				chan_r <= iasq_next(3'h7, chen_r);
			end else if (store) begin
				chan_r <= iasq_next(chan_r, chen_r);
			end
			if (done_ok) begin
				cor_r <= iasq_correct(ADC_DATA, offs_r[chan_r],
					gain_r[chan_r], sel_r[chan_r]);
			end
		end
	end

	// Immediate path; buffered samples go to the FIFO instead.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			SAMPLE_VALID <= 1'b0;
			SAMPLE_DATA <= 16'h0;
			SAMPLE_CHAN <= 3'h0;
		end else begin
			SAMPLE_VALID <= store && !buf_r;
			if (store && !buf_r) begin
				SAMPLE_DATA <= cor_r;
				SAMPLE_CHAN <= chan_r;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (push) begin
			mem[wp_r] <= {chan_r, cor_r};
		end
	end

	// An overflow in the clearing cycle keeps the flag set.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			ovf_r <= 1'b0;
		end else begin
			wp_r <= push ? wp_r + 1'b1 : wp_r;
			rp_r <= pop ? rp_r + 1'b1 : rp_r;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
			ovf_r <= ovf_set || (ovf_r && !ovf_clr);
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			LED_PWR_GREEN <= 1'b0;
			LED_UP_GREEN <= 1'b0;
			LED_UP_RED <= 1'b0;
			LED_DOWN_BLUE <= 1'b0;
		end else begin
			LED_PWR_GREEN <= 1'b1;
			LED_UP_GREEN <= UPSTREAM_CONN;
			LED_UP_RED <= !UPSTREAM_CONN;
			LED_DOWN_BLUE <= DOWNSTREAM_CONN;
		end
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	a_id_default: assert property (
		BOARD_ID_SW_ON == 4'hf |=> id_r == 4'h0)
		else $error("identity not zero with all switches on");
	a_id_order: assert property (
		BOARD_ID_SW_ON == 4'h7 |=> id_r == 4'h8)
		else $error("position 1 is not the identity msb");
	// The first cycle after reset is excluded so the release edge cannot trip it.
	a_pwr_led: assert property (
		!$past(RESET) |-> LED_PWR_GREEN)
		else $error("power indicator off after reset");
	a_up_led: assert property (
		!UPSTREAM_CONN |=> LED_UP_RED && !LED_UP_GREEN && !run_r)
		else $error("upstream loss not shown or not halted");
	a_down_led: assert property (
		!$past(RESET) |-> LED_DOWN_BLUE == $past(DOWNSTREAM_CONN))
		else $error("downstream indicator wrong");
	a_mux_hold: assert property (
		state_r == iasq_pkg::IASQ_CONV |-> $stable(MUX_SEL))
		else $error("mux moved during conversion");
	a_skip_off: assert property (
		ADC_CONVST |-> chen_r[MUX_SEL])
		else $error("disabled channel converted");
	a_scan_next: assert property (
		store |=> chan_r == iasq_next($past(chan_r), chen_r))
		else $error("scan order broken");
	a_tick_gap: assert property (
		tick_r |=> !tick_r [*8])
		else $error("sample ticks too close");
	a_none_on: assert property (
		chen_r == 8'h00 |=> !ADC_CONVST && !push)
		else $error("conversion with no channel enabled");
	a_imm_path: assert property (
		SAMPLE_VALID |-> !$past(buf_r) && SAMPLE_CHAN == $past(chan_r))
		else $error("immediate sample misrouted");

	c_buf_push: cover property (push);
	c_imm_out: cover property (SAMPLE_VALID);
	c_overflow: cover property (ovf_set);
	c_wrap: cover property (store && chan_r > iasq_next(chan_r, chen_r));
endmodule
`default_nettype wire

// File: iasq_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module iasq_adc_model (
	input  wire logic        clk,	// converter clock
	input  wire logic        slow,	// long conversion when high
	input  wire logic        convst,	// conversion start pulse
	input  wire logic [2:0]  mux_sel,	// routed channel
	output logic             done,	// one-cycle done pulse
	output logic [15:0]      data	// code, valid with done
);
	logic [5:0] wait_r;
	logic       busy_r;
	initial begin
		done = 1'b0;
		data = 16'h0000;
		busy_r = 1'b0;
		wait_r = 6'h00;
	end
	// The code depends on the routed channel so a wrong mux shows up.
	always @(posedge clk) begin
		done <= 1'b0;
		data <= ~data;
		if (convst) begin
			busy_r <= 1'b1;
			wait_r <= slow ? 6'h28 : 6'h02;
		end else if (busy_r && wait_r == 6'h00) begin
			busy_r <= 1'b0;
			done <= 1'b1;
			data <= {1'b0, mux_sel, 12'h5a3};
		end else if (busy_r) begin
			wait_r <= wait_r - 6'h01;
		end
	end
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int LIMIT = 60000;
	logic        mclk, reset, hsel, hwrite, hrdy, hresp, up, dn, slow;
	logic        cst, done, sv, lpw, lug, lur, ldb;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize, mux, sch;
	logic [3:0]  id_on;
	logic [7:0]  cur;
	logic [15:0] adat, sdat;
	logic [18:0] seen[$];
	int          fail_count, total_checks, cycles, convs, n, i;
	iasq_scan_seq #(.DEPTH(4), .AW(2)) uut (.MCLK(mclk), .RESET(reset),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
		.HREADYOUT(hrdy), .HRESP(hresp), .BOARD_ID_SW_ON(id_on),
		.TYPE_SEL_CURRENT(cur), .UPSTREAM_CONN(up), .DOWNSTREAM_CONN(dn),
		.LED_PWR_GREEN(lpw), .LED_UP_GREEN(lug), .LED_UP_RED(lur),
		.LED_DOWN_BLUE(ldb), .MUX_SEL(mux), .ADC_CONVST(cst),
		.ADC_DONE(done), .ADC_DATA(adat), .SAMPLE_VALID(sv),
		.SAMPLE_DATA(sdat), .SAMPLE_CHAN(sch));
	iasq_adc_model adc (.clk(mclk), .slow(slow), .convst(cst),
		.mux_sel(mux), .done(done), .data(adat));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// A hung wait anywhere is cut short here rather than in each task.
	always @(posedge mclk) begin
		cycles++;
		if (cst === 1'b1)
			convs++;
		if (sv === 1'b1)
			seen.push_back({sch, sdat});
		if (cycles == LIMIT) begin
			fail_count++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a,
			input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		@(posedge mclk);
		while (hrdy !== 1'b1) @(posedge mclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge mclk);
		while (hrdy !== 1'b1) @(posedge mclk);
		rd = hrdata;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
			input logic [31:0] e);
		ahb(1'b0, a, 32'h00000000);
		chk(nm, e, rd);
	endtask
	function automatic logic [15:0] expd(input logic [2:0] c);
		case (c)
			3'h1: expd = 16'h16a3;
			3'h2: expd = 16'h12d1;
			// Current mode floors at mid-scale, which the host reads as 0 mA.
			3'h4: expd = 16'h8000;
			default: expd = {1'b0, c, 12'h5a3};
		endcase
	endfunction
	initial begin
		reset = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		id_on = 4'hf;
		cur = 8'ha5;
		up = 1'b1;
		dn = 1'b1;
		slow = 1'b0;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("led_pwr", 32'h1, lpw);
		chk("led_up_green", 32'h1, lug);
		chk("led_down", 32'h1, ldb);
		rchk("ctrl", 8'h00, 32'h4);
		rchk("chen", 8'h04, 32'h0);
		rchk("gain0", 8'h40, 32'h8000);
		rchk("unmapped", 8'h80, 32'h0);
		chk("hresp", 32'h0, hresp);
		ahb(1'b1, 8'h08, 32'd5);
		rchk("div", 8'h08, 32'd200);
		rchk("status", 8'h0c, 32'h0000a50c);
		id_on <= 4'b0111;
		cur <= 8'h10;
		dn <= 1'b0;
		ahb(1'b1, 8'h24, 32'h0100);
		ahb(1'b1, 8'h48, 32'h4000);
		ahb(1'b1, 8'h04, 32'h36);
		chk("led_down_off", 32'h0, ldb);
		rchk("status_id", 8'h0c, 32'h00001084);
		seen.delete();
		ahb(1'b1, 8'h00, 32'h1);
		while (seen.size() < 6) @(posedge mclk);
		ahb(1'b1, 8'h00, 32'h2);
		for (i = 0; i < 6; i++) begin
			n = (i % 4 == 3) ? 5 : (i % 4 == 2) ? 4 : (i % 4) + 1;
			chk("chan", n, seen[i][18:16]);
			chk("data", expd(n[2:0]), seen[i][15:0]);
		end
		ahb(1'b1, 8'h00, 32'h1);
		n = convs + 1;
		while (convs < n) @(posedge mclk);
		up <= 1'b0;
		repeat (4) @(posedge mclk);
		chk("led_up_red", 32'h1, lur);
		chk("led_up_green_off", 32'h0, lug);
		rchk("status_halt", 8'h0c, 32'h00001080);
		n = convs;
		repeat (2500) @(posedge mclk);
		chk("halted_convs", n, convs);
		up <= 1'b1;
		ahb(1'b1, 8'h04, 32'h0);
		ahb(1'b1, 8'h00, 32'h1);
		repeat (2500) @(posedge mclk);
		chk("no_chan_convs", n, convs);
		rchk("no_chan_fifo", 8'h0c, 32'h00001084);
		slow <= 1'b1;
		ahb(1'b1, 8'h04, 32'h81);
		ahb(1'b1, 8'h00, 32'h5);
		while (convs < n + 3) @(posedge mclk);
		repeat (60) @(posedge mclk);
		ahb(1'b1, 8'h00, 32'h6);
		rchk("fifo_count", 8'h0c, 32'h00031084);
		for (i = 0; i < 3; i++) begin
			n = (i == 1) ? 7 : 0;
			rchk("fifo", 8'h10, {13'h1000, n[2:0], expd(n)});
		end
		ahb(1'b0, 8'h10, 32'h0);
		chk("fifo_empty", 32'h0, rd[31]);
		// Five samples into a four-deep FIFO: the last is dropped and flagged.
		n = convs;
		ahb(1'b1, 8'h04, 32'h08);
		ahb(1'b1, 8'h00, 32'h5);
		while (convs < n + 5) @(posedge mclk);
		repeat (60) @(posedge mclk);
		ahb(1'b1, 8'h00, 32'h6);
		rchk("fifo_ovf", 8'h0c, 32'h00041086);
		ahb(1'b1, 8'h0c, 32'h2);
		rchk("ovf_clear", 8'h0c, 32'h00041084);
		test_done();
	end
endmodule
`default_nettype wire
